// *** mmpc_pkg.sv ***
package mmpc_pkg;
    localparam int CLK_HZ           = 40_000_000;
    localparam int BEACON_PERIOD_MS = 1000;
    localparam int BEACON_ON_MS     = 100;
    localparam int DEBOUNCE_MS      = 1;
    localparam int PWM_TICK_DIV     = 16;
    localparam int RX_FIFO_DEPTH    = 8;
    localparam int PADDR_W          = 8;

    localparam logic [7:0] A_CTRL       = 8'h00;
    localparam logic [7:0] A_DEVTYPE    = 8'h04;
    localparam logic [7:0] A_REMOTE     = 8'h08;
    localparam logic [7:0] A_PWM_DUTY   = 8'h0c;
    localparam logic [7:0] A_LAMP_COLOR = 8'h10;
    localparam logic [7:0] A_KEY_TARGET = 8'h14;
    localparam logic [7:0] A_SHORT_ADDR = 8'h18;
    localparam logic [7:0] A_STATUS     = 8'h1c;
    localparam logic [7:0] A_RX_DATA    = 8'h20;
    localparam logic [7:0] A_TX_DATA    = 8'h24;
    localparam logic [7:0] A_KEY_EVENT  = 8'h28;
    localparam logic [7:0] A_BAUD       = 8'h2c;

    localparam int CTRL_LINK    = 0;
    localparam int CTRL_MESH    = 1;
    localparam int CTRL_FACTORY = 2;
    localparam int ST_LINK      = 0;
    localparam int ST_CMD_MODE  = 1;
    localparam int ST_ALL_LEVEL = 2;
    localparam int ST_RX_VALID  = 3;
    localparam int ST_TX_BUSY   = 4;
    localparam int ST_OVERRUN   = 5;
    localparam int ST_FRAME_ERR = 6;
    localparam int ST_KEY_PEND  = 7;

    localparam logic [7:0]  TYPE_TRANSPARENT = 8'ha0;
    localparam logic [7:0]  TYPE_LAMP        = 8'hb1;
    localparam logic [7:0]  TYPE_REMOTE      = 8'hc0;
    localparam logic [7:0]  DEVTYPE_RST      = 8'ha0;
    localparam logic [31:0] KEY_TARGET_RST   = 32'hffffffff;
    localparam logic [7:0]  BROADCAST_ADDR   = 8'hff;
    localparam logic [2:0]  BAUD_RST         = 3'h0;
    localparam logic [2:0]  ALL_KEY_CODE     = 3'h5;

    typedef struct packed {
        logic       cmd;
        logic [7:0] data;
    } mmpc_rx_word_t;

    typedef struct packed {
        logic       level;
        logic [2:0] key;
        logic [7:0] target;
    } mmpc_key_evt_t;

    function automatic logic [15:0] mmpc_baud_div(input logic [2:0] sel);
        case (sel)
            3'h1:    mmpc_baud_div = 16'(CLK_HZ / 57600);
            3'h2:    mmpc_baud_div = 16'(CLK_HZ / 38400);
            3'h3:    mmpc_baud_div = 16'(CLK_HZ / 19200);
            3'h4:    mmpc_baud_div = 16'(CLK_HZ / 9600);
            3'h5:    mmpc_baud_div = 16'(CLK_HZ / 4800);
            default: mmpc_baud_div = 16'(CLK_HZ / 115200);
        endcase
    endfunction
endpackage

// *** mmpc_top.sv ***
// Overview of operation
// (R1) link_state_out is low without a wireless connection and high once connected.
// (R2) While mesh operation runs, beacon_led_out pulses once a second, high for 100 ms.
// (R3) When connected, the host holds cmd_select_in low to have serial bytes taken as commands.
// (R4) When connected with cmd_select_in high, serial bytes pass through as transparent data.
// (R5) Without a connection every serial byte is a command, whatever cmd_select_in shows.
// (R6) The four remote_out lines follow the mesh-commanded level and keep it across reconnects; the code holds them low while dev_type is TYPE_REMOTE.
// (R7) Each all_toggle_key press commands all outputs low, the next press high, alternately.
// (R8) A press of key_in_1..4 sends that key's code to the target short address set for it.
// (R9) In transparent type all four pwm_out pins are general-purpose PWM outputs.
// (R10) In lamp type pwm_out_0..3 drive red, blue, green and white.
// (R11) After a factory reset the short address becomes the last byte of the MAC address.
// (R12) The serial rate defaults to 115200 and may be 57600, 38400, 19200, 9600 or 4800.
// (R13) The host ends every command with CR LF in exact letter case.
// (R14) Serial framing is one start bit, eight data bits LSB first, no parity, one stop bit.
// (R15) While the reset pin is low the block stays in reset and resumes when it is high; the code does not clear remote_level on the pin, it keeps its value.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
module mmpc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Depth is a power of two, so the pointers wrap by themselves
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module mmpc_top
    import mmpc_pkg::*;
#(
    parameter int BEACON_PERIOD_CYC = CLK_HZ / 1000 * BEACON_PERIOD_MS,
    parameter int BEACON_ON_CYC     = CLK_HZ / 1000 * BEACON_ON_MS,
    parameter int DEBOUNCE_CYC      = CLK_HZ / 1000 * DEBOUNCE_MS
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               reset_n_pin,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [7:0]         mac_last_byte,
    input  wire logic               uart_rx_in,
    output logic                    uart_tx_out,
    input  wire logic               cmd_select_in,
    input  wire logic               key_in_1,
    input  wire logic               key_in_2,
    input  wire logic               key_in_3,
    input  wire logic               key_in_4,
    input  wire logic               all_toggle_key,
    output logic                    link_state_out,
    output logic                    beacon_led_out,
    output logic [3:0]              remote_out,
    output logic                    pwm_out_0,
    output logic                    pwm_out_1,
    output logic                    pwm_out_2,
    output logic                    pwm_out_3
);
    wire sys_rst = rst || !reset_n_pin; // see (R15)

    logic [2:0]    ctrl;
    logic [7:0]    dev_type;
    logic [3:0]    remote_level;
    logic [31:0]   pwm_duty;
    logic [31:0]   lamp_color;
    logic [31:0]   key_target;
    logic [7:0]    short_addr;
    logic          addr_loaded;
    logic [2:0]    baud_sel;
    logic          all_level;
    logic          overrun;
    logic          frame_err;
    logic          key_pend;
    mmpc_key_evt_t key_evt;

    // APB slave: one wait state, the answer is registered
    wire hit_ctrl  = (paddr == A_CTRL);
    wire hit_type  = (paddr == A_DEVTYPE);
    wire hit_rem   = (paddr == A_REMOTE);
    wire hit_duty  = (paddr == A_PWM_DUTY);
    wire hit_lamp  = (paddr == A_LAMP_COLOR);
    wire hit_ktgt  = (paddr == A_KEY_TARGET);
    wire hit_addr  = (paddr == A_SHORT_ADDR);
    wire hit_stat  = (paddr == A_STATUS);
    wire hit_rx    = (paddr == A_RX_DATA);
    wire hit_tx    = (paddr == A_TX_DATA);
    wire hit_kevt  = (paddr == A_KEY_EVENT);
    wire hit_baud  = (paddr == A_BAUD);
    wire hit_any   = hit_ctrl || hit_type || hit_rem || hit_duty || hit_lamp || hit_ktgt
                     || hit_addr || hit_stat || hit_rx || hit_tx || hit_kevt || hit_baud;
    wire apb_done  = psel && penable && pready;
    wire wr_done   = apb_done && pwrite && hit_any;
    wire rd_done   = apb_done && !pwrite && hit_any;

    logic          tx_busy;
    logic          rx_out_valid;
    mmpc_rx_word_t rx_out_word;

    // A TX write waits in the access phase until the previous byte has left
    wire           can_answer = !(pwrite && hit_tx && tx_busy);
    wire           cmd_mode   = !ctrl[CTRL_LINK] || !cmd_select_in; // see (R3) (R4) (R5)
    wire [7:0]     status     = {key_pend, frame_err, overrun, tx_busy, rx_out_valid,
                                 all_level, cmd_mode, ctrl[CTRL_LINK]};
    wire [31:0]    rd_data    =
        hit_ctrl ? {29'h0, ctrl} :
        hit_type ? {24'h0, dev_type} :
        hit_rem  ? {28'h0, remote_level} :
        hit_duty ? pwm_duty :
        hit_lamp ? lamp_color :
        hit_ktgt ? key_target :
        hit_addr ? {24'h0, short_addr} :
        hit_stat ? {24'h0, status} :
        hit_rx   ? {22'h0, rx_out_valid, rx_out_word} :
        hit_kevt ? {19'h0, key_pend, key_evt} :
        hit_baud ? {29'h0, baud_sel} : 32'h0;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && penable && !pready && can_answer;
            pslverr <= psel && penable && !pready && can_answer && !hit_any;
            prdata  <= (psel && !pwrite) ? rd_data : 32'h0;
        end
    end

    wire factory = wr_done && hit_ctrl && pwdata[CTRL_FACTORY];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl       <= 3'h0;
            dev_type   <= DEVTYPE_RST;
            pwm_duty   <= 32'h0;
            lamp_color <= 32'h0;
            key_target <= KEY_TARGET_RST;
            baud_sel   <= BAUD_RST;
        end else if (wr_done) begin
            ctrl       <= hit_ctrl ? {1'b0, pwdata[CTRL_MESH], pwdata[CTRL_LINK]} : ctrl;
            dev_type   <= hit_type ? pwdata[7:0] : dev_type;
            pwm_duty   <= hit_duty ? pwdata : pwm_duty;
            lamp_color <= hit_lamp ? pwdata : lamp_color;
            key_target <= (hit_ktgt || factory) ? (factory ? KEY_TARGET_RST : pwdata)
                                                 : key_target;
            baud_sel   <= factory ? BAUD_RST : (hit_baud ? pwdata[2:0] : baud_sel);
        end
    end

    // Strap is caught after reset release, never by the reset itself
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr_loaded <= 1'b0;
            short_addr  <= 8'h0;
        end else begin
            addr_loaded <= 1'b1;
            if (!addr_loaded || factory) begin
                short_addr <= mac_last_byte; // see (R11)
            end else if (wr_done && hit_addr) begin
                short_addr <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            link_state_out <= 1'b0;
        end else begin
            link_state_out <= ctrl[CTRL_LINK]; // see (R1)
        end
    end

    // Beacon indicator
    logic [25:0] beacon_cnt;
    always_ff @(posedge core_clk) begin
        if (sys_rst || !ctrl[CTRL_MESH]) begin
            beacon_cnt     <= 26'h0;
            beacon_led_out <= 1'b0;
        end else begin
            beacon_cnt     <= (beacon_cnt == 26'(BEACON_PERIOD_CYC - 1)) ? 26'h0
                                                                        : beacon_cnt + 26'h1;
            beacon_led_out <= (beacon_cnt < 26'(BEACON_ON_CYC)); // see (R2)
        end
    end

    // Keys, sampled on a slow tick so contact bounce is ignored
    logic [15:0] deb_cnt;
    logic        deb_tick;
    logic [4:0]  deb_a;
    logic [4:0]  deb_b;
    wire  [4:0]  key_raw = {all_toggle_key, key_in_4, key_in_3, key_in_2, key_in_1};
    wire  [4:0]  press;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            deb_cnt  <= 16'h0;
            deb_tick <= 1'b0;
        end else begin
            deb_tick <= (deb_cnt == 16'(DEBOUNCE_CYC - 1));
            deb_cnt  <= (deb_cnt == 16'(DEBOUNCE_CYC - 1)) ? 16'h0 : deb_cnt + 16'h1;
        end
    end

    for (genvar k = 0; k < 5; k++) begin : g_key
        assign press[k] = deb_tick && key_raw[k] && deb_a[k] && !deb_b[k];
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                deb_a[k] <= 1'b0;
                deb_b[k] <= 1'b0;
            end else if (deb_tick) begin
                deb_a[k] <= key_raw[k];
                deb_b[k] <= deb_a[k];
            end
        end
    end

    function automatic logic [1:0] first_key(input logic [3:0] p);
        first_key = p[0] ? 2'd0 : p[1] ? 2'd1 : p[2] ? 2'd2 : 2'd3;
    endfunction

    wire [1:0]     key_idx  = first_key(press[3:0]);
    wire [7:0]     key_dest = key_target[8*key_idx +: 8];
    wire           evt_rd   = rd_done && hit_kevt;
    wire           any_key  = |press;
    // The all-off/all-on key outranks the others when both land in one tick
    wire mmpc_key_evt_t next_evt = press[4]
        ? {!all_level, ALL_KEY_CODE, BROADCAST_ADDR}
        : {1'b1, {1'b0, key_idx} + 3'h1, key_dest}; // see (R8)

    // A new press in the cycle of the clearing read stays pending
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            key_pend  <= 1'b0;
            key_evt   <= '0;
            all_level <= 1'b1;
        end else begin
            key_pend  <= any_key || (key_pend && !evt_rd);
            key_evt   <= any_key ? next_evt : key_evt;
            all_level <= press[4] ? !all_level : all_level; // see (R7)
        end
    end

    // Kept through the reset pin and link loss; only a power-on reset clears it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            remote_level <= 4'h0;
        end else if (reset_n_pin && press[4]) begin
            remote_level <= {4{!all_level}}; // see (R7)
        end else if (reset_n_pin && wr_done && hit_rem) begin
            remote_level <= pwdata[3:0]; // see (R6)
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            remote_out <= 4'h0;
        end else begin
            remote_out <= (dev_type == TYPE_REMOTE) ? 4'h0 : remote_level; // see (R6)
        end
    end

    // PWM
    logic [3:0]  pwm_div;
    logic [7:0]  pwm_cnt;
    logic [3:0]  pwm_q;
    wire  [31:0] lamp_map = {lamp_color[31:24], lamp_color[15:8],
                             lamp_color[23:16], lamp_color[7:0]}; // see (R10)
    wire  [31:0] duty_sel = (dev_type == TYPE_LAMP) ? lamp_map : pwm_duty; // see (R9)
    wire         pwm_on   = (dev_type == TYPE_TRANSPARENT) || (dev_type == TYPE_LAMP);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pwm_div <= 4'h0;
            pwm_cnt <= 8'h0;
        end else begin
            pwm_div <= (pwm_div == 4'(PWM_TICK_DIV - 1)) ? 4'h0 : pwm_div + 4'h1;
            pwm_cnt <= (pwm_div == 4'(PWM_TICK_DIV - 1)) ? pwm_cnt + 8'h1 : pwm_cnt;
        end
    end

    for (genvar c = 0; c < 4; c++) begin : g_pwm
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                pwm_q[c] <= 1'b0;
            end else begin
                pwm_q[c] <= pwm_on && (pwm_cnt < duty_sel[8*c +: 8]); // see (R9) (R10)
            end
        end
    end
    assign pwm_out_0 = pwm_q[0];
    assign pwm_out_1 = pwm_q[1];
    assign pwm_out_2 = pwm_q[2];
    assign pwm_out_3 = pwm_q[3];

    // Serial port; a rate change takes effect on the next bit boundary
    wire [15:0] bit_div = mmpc_baud_div(baud_sel); // see (R12)

    logic          rx_busy;
    logic [15:0]   rx_cnt;
    logic [3:0]    rx_bit;
    logic [7:0]    rx_shift;
    logic          hold_valid;
    mmpc_rx_word_t hold_word;
    logic          hold_ready;
    wire           rx_tick  = rx_busy && (rx_cnt == 16'h0);
    wire           rx_good  = rx_tick && (rx_bit == 4'd9) && uart_rx_in;
    wire           rx_bad   = rx_tick && (rx_bit == 4'd9) && !uart_rx_in;
    wire           rx_pop   = rd_done && hit_rx;
    wire           st_clear = wr_done && hit_stat;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_busy  <= 1'b0;
            rx_cnt   <= 16'h0;
            rx_bit   <= 4'h0;
            rx_shift <= 8'h0;
        end else if (!rx_busy) begin
            rx_busy <= !uart_rx_in;
            rx_cnt  <= bit_div >> 1;
            rx_bit  <= 4'h0;
        end else if (rx_tick) begin
            rx_cnt <= bit_div - 16'h1;
            if (rx_bit == 4'h0) begin
                rx_busy <= !uart_rx_in;
                rx_bit  <= 4'h1;
            end else if (rx_bit != 4'd9) begin
                rx_shift <= {uart_rx_in, rx_shift[7:1]}; // see (R14)
                rx_bit   <= rx_bit + 4'h1;
            end else begin
                rx_busy <= 1'b0;
            end
        end else begin
            rx_cnt <= rx_cnt - 16'h1;
        end
    end

    // Holding stage waits for FIFO room; a byte arriving while it is full is lost
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hold_valid <= 1'b0;
            hold_word  <= '0;
            overrun    <= 1'b0;
            frame_err  <= 1'b0;
        end else begin
            hold_valid <= rx_good || (hold_valid && !hold_ready);
            hold_word  <= (rx_good && !(hold_valid && !hold_ready))
                          ? {cmd_mode, rx_shift} : hold_word; // see (R3) (R4) (R5)
            overrun    <= (rx_good && hold_valid && !hold_ready)
                          || (overrun && !(st_clear && pwdata[ST_OVERRUN]));
            frame_err  <= rx_bad || (frame_err && !(st_clear && pwdata[ST_FRAME_ERR]));
        end
    end

    mmpc_fifo #(
        .WIDTH ($bits(mmpc_rx_word_t)),
        .DEPTH (RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (core_clk),
        .rst       (sys_rst),
        .in_valid  (hold_valid),
        .in_ready  (hold_ready),
        .in_data   (hold_word),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out_word)
    );

    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [8:0]  tx_shift;
    wire         tx_start = wr_done && hit_tx;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_busy     <= 1'b0;
            tx_cnt      <= 16'h0;
            tx_bit      <= 4'h0;
            tx_shift    <= 9'h1ff;
            uart_tx_out <= 1'b1;
        end else if (tx_start) begin
            tx_busy     <= 1'b1;
            tx_cnt      <= bit_div - 16'h1;
            tx_bit      <= 4'h0;
            tx_shift    <= {1'b1, pwdata[7:0]};
            uart_tx_out <= 1'b0; // see (R14)
        end else if (tx_busy && tx_cnt != 16'h0) begin
            tx_cnt <= tx_cnt - 16'h1;
        end else if (tx_busy) begin
            tx_cnt <= bit_div - 16'h1;
            if (tx_bit == 4'd9) begin
                tx_busy <= 1'b0;
            end else begin
                uart_tx_out <= tx_shift[0];
                tx_shift    <= {1'b1, tx_shift[8:1]};
                tx_bit      <= tx_bit + 4'h1;
            end
        end
    end
endmodule

// *** mmpc_host.sv ***
`timescale 1ns/100ps
module mmpc_host #(
    parameter int DIV = 347
) (
    input  wire logic clk,
    input  wire logic rx_line,
    output logic      tx_line
);
    logic [7:0] got;
    int         n_got;
    initial begin
        tx_line = 1'b1;
        n_got = 0;
    end
    // Start bit, eight data bits LSB first, stop bit; line idles high
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            tx_line <= f[i];
            repeat (DIV) @(posedge clk);
        end
    endtask
    // Mid-bit sampling keeps margin against a drifting divider
    always begin
        @(negedge rx_line);
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk);
            got[i] = rx_line;
        end
        repeat (DIV) @(posedge clk);
        n_got++;
    end
endmodule

// *** mmpc_top_chk.sv ***
`timescale 1ns/100ps
module mmpc_chk
    import mmpc_pkg::*;
#(
    parameter int BEACON_ON_CYC = 100
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        reset_n_pin,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        uart_tx_out,
    input wire logic        link_state_out,
    input wire logic        beacon_led_out,
    input wire logic [3:0]  remote_out,
    input wire logic        pwm_out_0
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [31:0] on_cnt;
    // Width of the current beacon pulse, compared when it ends
    always_ff @(posedge core_clk) begin
        on_cnt <= beacon_led_out ? on_cnt + 32'h1 : 32'h0;
    end
    sequence s_rd;
        psel && !penable && !pwrite ##1 psel && penable;
    endsequence
    pin_link_a: assert property (!reset_n_pin |=>
        !link_state_out && !beacon_led_out)
        else $error("link or beacon active in pin reset");
    pin_outs_a: assert property (!reset_n_pin |=>
        remote_out == 4'h0 && uart_tx_out && !pwm_out_0)
        else $error("outputs active in pin reset");
    beacon_width_a: assert property ($fell(beacon_led_out) |->
        on_cnt == BEACON_ON_CYC)
        else $error("beacon pulse width wrong");
    tx_start_a: assert property ($fell(uart_tx_out) |-> !uart_tx_out [*8])
        else $error("start bit too short");
    rd_answer_a: assert property (s_rd |=> pready)
        else $error("read not answered after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    slverr_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an answer");
    rdata_idle_a: assert property (!$past(psel) |-> prdata == 32'h0)
        else $error("read data driven while idle");
endmodule
bind mmpc_top mmpc_chk #(.BEACON_ON_CYC(BEACON_ON_CYC)) u_chk (.*);

// *** tb_mmpc_top.sv ***
`timescale 1ns/100ps
module tb_mmpc_top;
    import mmpc_pkg::*;
    localparam int PER = 1000;
    localparam int ON  = 100;
    logic        core_clk, rst, reset_n_pin, psel, penable, pwrite, pready, pslverr;
    logic        uart_rx, uart_tx, cmd_select_in, all_toggle_key, link, beacon, e;
    logic [7:0]  paddr, mac;
    logic [31:0] pwdata, prdata, q, rnd;
    logic [3:0]  key, remote;
    wire  [3:0]  pwm;
    int          n_errors, comparisons, n;
    mmpc_top #(.BEACON_PERIOD_CYC(PER), .BEACON_ON_CYC(ON), .DEBOUNCE_CYC(8)) u_dut (
        .core_clk(core_clk), .rst(rst), .reset_n_pin(reset_n_pin), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac_last_byte(mac),
        .uart_rx_in(uart_rx), .uart_tx_out(uart_tx), .cmd_select_in(cmd_select_in),
        .key_in_1(key[0]), .key_in_2(key[1]), .key_in_3(key[2]), .key_in_4(key[3]),
        .all_toggle_key(all_toggle_key), .link_state_out(link), .beacon_led_out(beacon),
        .remote_out(remote), .pwm_out_0(pwm[0]), .pwm_out_1(pwm[1]),
        .pwm_out_2(pwm[2]), .pwm_out_3(pwm[3]));
    mmpc_host #(.DIV(CLK_HZ / 115200)) u_host (.clk(core_clk), .rx_line(uart_tx),
        .tx_line(uart_rx));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Lamp colour bytes in pin order: red, blue, green, white
    function automatic logic [31:0] lamp(input logic [31:0] c);
        return {c[31:24], c[15:8], c[23:16], c[7:0]};
    endfunction
    task automatic end_sim;
        if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic press(input int k);
        if (k == 4) all_toggle_key <= 1'b1;
        else key[k] <= 1'b1;
        repeat (40) @(posedge core_clk);
        all_toggle_key <= 1'b0;
        key <= 4'h0;
        repeat (40) @(posedge core_clk);
    endtask
    // Any 4096-cycle window holds one full PWM period, so the high count is exact
    task automatic pwm_chk(input logic [31:0] exp);
        int h[4] = '{default: 0};
        repeat (4096) begin
            @(posedge core_clk);
            for (int i = 0; i < 4; i++) h[i] += pwm[i];
        end
        for (int i = 0; i < 4; i++) check("pwm", h[i], exp[8*i+:8] * 16);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #(25 * 60000);
        n_errors++;
        end_sim();
    end
    initial begin
        {rst, reset_n_pin} = 2'b11;
        {psel, penable, pwrite, cmd_select_in, all_toggle_key} = 5'h0;
        {paddr, pwdata, key, mac, rnd} = {8'h0, 32'h0, 4'h0, 8'h3c, 32'h7915};
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        apb(0, A_SHORT_ADDR, 0);
        check("short", q, 8'h3c);
        apb(0, A_DEVTYPE, 0);
        check("type", q, TYPE_TRANSPARENT);
        apb(0, 8'h40, 0);
        check("slverr", e, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(lfsr(rnd));
            cmd_select_in <= (i != 2);
            apb(1, A_CTRL, (i != 0));
            u_host.send(rnd[7:0]);
            repeat (20) @(posedge core_clk);
            check("link", link, (i != 0));
            apb(0, A_RX_DATA, 0);
            check("rx", q[9:0], {1'b1, i != 1, rnd[7:0]});
        end
        u_host.send(8'h0d);
        u_host.send(8'h0a);
        n = u_host.n_got;
        apb(1, A_TX_DATA, rnd);
        repeat (5000) if (u_host.n_got == n) @(posedge core_clk);
        check("tx", u_host.got, rnd[7:0]);
        apb(1, A_REMOTE, rnd[11:8]);
        apb(1, A_CTRL, 0);
        reset_n_pin <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("keep", remote, rnd[11:8]);
        check("link", link, 1'b0);
        for (int p = 0; p < 2; p++) begin
            press(4);
            check("all", remote, {4{p[0]}});
        end
        apb(0, A_KEY_EVENT, 0);
        check("allev", q[12:0], {2'b11, ALL_KEY_CODE, BROADCAST_ADDR});
        rnd = lfsr(lfsr(rnd));
        apb(1, A_KEY_TARGET, rnd);
        for (int k = 0; k < 4; k++) begin
            press(k);
            apb(0, A_KEY_EVENT, 0);
            check("key", {q[12], q[10:0]}, {1'b1, 3'(k + 1), rnd[8*k+:8]});
        end
        apb(1, A_CTRL, 32'h2);
        repeat (PER) if (beacon !== 1'b1) @(posedge core_clk);
        repeat (PER) if (beacon === 1'b1) @(posedge core_clk);
        n = 0;
        while (beacon !== 1'b1 && n < PER) begin
            @(posedge core_clk);
            n++;
        end
        check("beacon", n, PER - ON);
        repeat (ON + 5) @(posedge core_clk);
        apb(1, A_CTRL, 0);
        repeat (PER) @(posedge core_clk);
        check("beacon off", beacon, 1'b0);
        rnd = lfsr(lfsr(rnd));
        apb(1, A_PWM_DUTY, rnd);
        pwm_chk(rnd);
        apb(1, A_DEVTYPE, TYPE_LAMP);
        apb(1, A_LAMP_COLOR, ~rnd);
        pwm_chk(lamp(~rnd));
        apb(1, A_DEVTYPE, TYPE_REMOTE);
        pwm_chk(0);
        apb(1, A_BAUD, 3'h5);
        apb(0, A_BAUD, 0);
        check("baud", q[2:0], 3'h5);
        mac <= rnd[23:16];
        apb(1, A_CTRL, 32'h4);
        apb(0, A_SHORT_ADDR, 0);
        check("factory", q[7:0], rnd[23:16]);
        apb(0, A_BAUD, 0);
        check("baud", q[2:0], BAUD_RST);
        end_sim();
    end
endmodule
